//--- hdl/stop_seq_regs.vh
// constants for the stop and fault response sequencer
`ifndef STOP_SEQ_REGS_VH
`define STOP_SEQ_REGS_VH
`define CLK_HZ 10000000
`define ENABLE_OFF_DELAY_MS 100
`define SETPOINT_RAMP_MS 10
`define BRAKE_TIMEOUT_MS 5000
`define ENABLE_OFF_DELAY_CYC ((`ENABLE_OFF_DELAY_MS * (`CLK_HZ / 1000)))
`define SETPOINT_RAMP_CYC ((`SETPOINT_RAMP_MS * (`CLK_HZ / 1000)))
`define BRAKE_TIMEOUT_CYC ((`BRAKE_TIMEOUT_MS * (`CLK_HZ / 1000)))
`define BRAKE_SPEED_RPM 5
`define CODE_NONE 8'h00
`define CODE_WARN_PHASE 8'h05
`define CODE_ERR_UNDERVOLT 8'h05
`define CODE_ERR_PHASE 8'h19
`define CODE_MAINS_READY 8'h16
`define CODE_ERR_HARD 8'hFF
`define KIND_NONE 2'h0
`define KIND_WARN 2'h1
`define KIND_ERR 2'h2
`endif

//--- hdl/sync2.v
// two flip-flop synchroniser
`timescale 1ns/1ps
module sync2 #(
	parameter W = 1
) (
	input wire core_clk_i,
	input wire rst_n_i,
	input wire ce_i,
	input wire [W-1:0] d_i,
	output wire [W-1:0] q_o
);
	reg [W-1:0] s1_q;
	reg [W-1:0] s2_q;
	always @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s1_q <= {W{1'b0}};
			s2_q <= {W{1'b0}};
		end else if (ce_i) begin
			s1_q <= d_i;
			s2_q <= s1_q;
		end
	end
	assign q_o = s2_q;
endmodule

//--- hdl/down_timer.v
// loadable down counter with expiry flag
`timescale 1ns/1ps
module down_timer #(
	parameter W = 26
) (
	input wire core_clk_i,
	input wire rst_n_i,
	input wire ce_i,
	input wire load_i,
	input wire [W-1:0] value_i,
	input wire run_i,
	output wire [W-1:0] count_o,
	output wire expired_o
);
	reg [W-1:0] cnt_q;
	always @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cnt_q <= {W{1'b0}};
		end else if (ce_i) begin
			if (load_i) begin
				cnt_q <= value_i;
			end else if (run_i && cnt_q != {W{1'b0}}) begin
				cnt_q <= cnt_q - {{(W-1){1'b0}}, 1'b1};
			end
		end
	end
	assign count_o = cnt_q;
	assign expired_o = (cnt_q == {W{1'b0}});
endmodule

//--- hdl/drive_stop_fault_sequencer.v
// stop and fault response sequencer of a servo drive
// Behaviour
// - both responses zero: coast, drive removed
// - both responses one: controlled ramp, then off
// - phase loss warning: warn, limit current, enabled
// - phase warning shows mains-ready on output
// - phase loss error: fault, disable, open contact
// - phase error with fault response: ramp first
// - undervoltage: fault, respond per configuration
// - brake enabled: enable loss brakes, special off
// - hard faults switch off at once
// - phase error ramps even with enable held
// - setpoint ramp 10 ms within 100 ms window
// - brake at 5 rpm or 5 s timeout
`timescale 1ns/1ps
`include "stop_seq_regs.vh"
module drive_stop_fault_sequencer #(
	parameter SPEED_W = 16,
	parameter TW = 26,
	parameter [TW-1:0] ENABLE_OFF_DELAY_CYC = `ENABLE_OFF_DELAY_CYC,
	parameter [TW-1:0] SETPOINT_RAMP_CYC = `SETPOINT_RAMP_CYC,
	parameter [TW-1:0] BRAKE_TIMEOUT_CYC = `BRAKE_TIMEOUT_CYC,
	parameter [SPEED_W-1:0] BRAKE_SPEED_RPM = `BRAKE_SPEED_RPM
) (
	input wire core_clk_i,
	input wire rst_n_i,
	input wire ce_i,
	// asynchronous pins
	input wire enable_i,
	input wire phase_loss_i,
	input wire undervoltage_i,
	input wire hard_fault_i,
	// configuration and measurements, same clock
	input wire enable_loss_response_i,
	input wire fault_response_select_i,
	input wire phase_loss_response_i,
	input wire brake_function_i,
	input wire [SPEED_W-1:0] speed_rpm_i,
	input wire [SPEED_W-1:0] setpoint_i,
	input wire clear_i,
	// stage, brake and status outputs
	output reg drive_on_o,
	output reg current_limit_o,
	output reg [SPEED_W-1:0] setpoint_o,
	output reg brake_engage_o,
	output reg ready_to_operate_contact_o,
	output reg mains_ready_out_o,
	output reg warning_o,
	output reg error_o,
	output reg [7:0] status_code_o,
	output reg [1:0] state_o
);
	// sequencer states
	localparam [1:0] S_IDLE = 2'h0;
	localparam [1:0] S_RUN = 2'h1;
	localparam [1:0] S_RAMP = 2'h2;
	localparam [1:0] S_OFF = 2'h3;

	// synchronised pins
	wire [3:0] pin_s;
	wire en_s = pin_s[0];
	wire phase_s = pin_s[1];
	wire uv_s = pin_s[2];
	wire hard_s = pin_s[3];
	// ramp window and brake timeout
	wire [TW-1:0] win_cnt;
	wire win_exp;
	wire [TW-1:0] brk_cnt;
	wire brk_exp;

	// sequencer state
	reg [1:0] st_q;
	reg [1:0] st_d;
	reg fault_q;
	reg ramp_load;
	reg [SPEED_W-1:0] step_q;

	// per-cycle ramp decrement, at least one
	function [SPEED_W-1:0] step_of;
		input [SPEED_W-1:0] sp;
		reg [TW+SPEED_W-1:0] q;
		begin
			q = {{TW{1'b0}}, sp} / {{SPEED_W{1'b0}}, SETPOINT_RAMP_CYC};
			step_of = (q[SPEED_W-1:0] == {SPEED_W{1'b0}}) ? {{(SPEED_W-1){1'b0}}, 1'b1} : q[SPEED_W-1:0];
		end
	endfunction

	// saturating subtraction down to zero
	function [SPEED_W-1:0] sat_sub;
		input [SPEED_W-1:0] a;
		input [SPEED_W-1:0] b;
		begin
			sat_sub = (a > b) ? a - b : {SPEED_W{1'b0}};
		end
	endfunction

	// code of the highest-priority active fault
	function [7:0] fault_code;
		input hard;
		input phase;
		begin
			if (hard) begin
				fault_code = `CODE_ERR_HARD;
			end else if (phase) begin
				fault_code = `CODE_ERR_PHASE;
			end else begin
				fault_code = `CODE_ERR_UNDERVOLT;
			end
		end
	endfunction

	// all four event pins come from outside the clock domain
	sync2 #(.W(4)) u_sync (
		.core_clk_i(core_clk_i),
		.rst_n_i(rst_n_i),
		.ce_i(ce_i),
		.d_i({hard_fault_i, undervoltage_i, phase_loss_i, enable_i}),
		.q_o(pin_s)
	);

	// window ends the ramp when no brake is fitted
	down_timer #(.W(TW)) u_window (
		.core_clk_i(core_clk_i),
		.rst_n_i(rst_n_i),
		.ce_i(ce_i),
		.load_i(ramp_load),
		.value_i(ENABLE_OFF_DELAY_CYC),
		.run_i(st_q == S_RAMP),
		.count_o(win_cnt),
		.expired_o(win_exp)
	);

	// brake timeout bounds every ramp
	down_timer #(.W(TW)) u_brake (
		.core_clk_i(core_clk_i),
		.rst_n_i(rst_n_i),
		.ce_i(ce_i),
		.load_i(ramp_load),
		.value_i(BRAKE_TIMEOUT_CYC),
		.run_i(st_q == S_RAMP),
		.count_o(brk_cnt),
		.expired_o(brk_exp)
	);

	// event qualification and ramp completion
	wire phase_err = phase_s && phase_loss_response_i;
	wire ctrl_stop = fault_response_select_i && enable_loss_response_i;
	wire any_fault = phase_err || uv_s;
	wire speed_low = (speed_rpm_i <= BRAKE_SPEED_RPM);
	wire ramp_done = speed_low || brk_exp || (win_exp && !brake_function_i);

	// next state
	always @* begin
		st_d = st_q;
		ramp_load = 1'b0;
		case (st_q)
			// waiting for enable with no fault held
			S_IDLE: begin
				if (en_s && !fault_q && !hard_s && !any_fault) begin
					st_d = S_RUN;
				end
			end
			// stage running, watching events
			S_RUN: begin
				if (hard_s) begin
					st_d = S_OFF;
				end else if (any_fault) begin
					// fault ramps even with enable held
					if (fault_response_select_i) begin
						st_d = S_RAMP;
						ramp_load = 1'b1;
					end else begin
						st_d = S_OFF;
					end
				end else if (!en_s) begin
					// ramp when controlled or braking, else coast
					if (ctrl_stop || brake_function_i) begin
						st_d = S_RAMP;
						ramp_load = 1'b1;
					end else begin
						st_d = S_OFF;
					end
				end
			end
			// controlled deceleration
			S_RAMP: begin
				if (hard_s) begin
					st_d = S_OFF;
				end else if (ramp_done) begin
					st_d = S_OFF;
				end
			end
			// stage off, brake engaged
			S_OFF: begin
				if (!en_s && speed_low) begin
					st_d = S_IDLE;
				end
			end
			default: begin
				st_d = S_IDLE;
			end
		endcase
	end

	// next-state decodes shared by the output registers
	wire run_next = (st_d == S_RUN);
	wire ramp_next = (st_d == S_RAMP);
	wire stop_next = (st_d == S_OFF) || (st_d == S_IDLE);
	wire phase_warn = phase_s && !phase_loss_response_i;
	wire fault_event = hard_s || any_fault;
	// first ramp step uses the fresh step, not the stale one
	wire [SPEED_W-1:0] step_now = ramp_load ? step_of(setpoint_o) : step_q;

	// state register
	always @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st_q <= S_IDLE;
			state_o <= S_IDLE;
		end else if (ce_i) begin
			st_q <= st_d;
			state_o <= st_d;
		end
	end

	// output stage, brake and current limit
	always @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			drive_on_o <= 1'b0;
			brake_engage_o <= 1'b1;
			current_limit_o <= 1'b0;
			mains_ready_out_o <= 1'b0;
		end else if (ce_i) begin
			drive_on_o <= run_next || ramp_next;
			// brake released only while the stage runs
			brake_engage_o <= stop_next;
			current_limit_o <= phase_warn && run_next;
			mains_ready_out_o <= phase_warn;
		end
	end

	// setpoint follows input while running, ramps down while stopping
	always @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			step_q <= {SPEED_W{1'b0}};
			setpoint_o <= {SPEED_W{1'b0}};
		end else if (ce_i) begin
			// step is held for the whole ramp
			if (ramp_load) begin
				step_q <= step_now;
			end
			if (run_next) begin
				setpoint_o <= setpoint_i;
			end else if (ramp_next) begin
				setpoint_o <= sat_sub(setpoint_o, step_now);
			end else begin
				setpoint_o <= {SPEED_W{1'b0}};
			end
		end
	end

	// latched status; set wins over clear
	always @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			fault_q <= 1'b0;
			error_o <= 1'b0;
			warning_o <= 1'b0;
			status_code_o <= `CODE_NONE;
		end else if (ce_i) begin
			if (fault_event) begin
				fault_q <= 1'b1;
				error_o <= 1'b1;
				warning_o <= 1'b0;
				status_code_o <= fault_code(hard_s, phase_err);
			end else if (phase_s && !fault_q) begin
				// warning latches only while no error is held
				warning_o <= 1'b1;
				status_code_o <= `CODE_WARN_PHASE;
			end else if (clear_i) begin
				fault_q <= 1'b0;
				error_o <= 1'b0;
				warning_o <= 1'b0;
				status_code_o <= `CODE_NONE;
			end
		end
	end

	// ready contact opens on any fault until cleared
	always @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ready_to_operate_contact_o <= 1'b0;
		end else if (ce_i) begin
			ready_to_operate_contact_o <= !(fault_event || fault_q);
		end
	end
endmodule

//--- verification/ctrl_model.sv
// machine controller model driving enable
`timescale 1ns/1ps
module ctrl_model (
	input wire core_clk_i,
	input wire rst_n_i,
	input wire start_i,
	input wire stop_i,
	output reg enable_o,
	output wire stopped_o
);
	assign stopped_o = !enable_o;  // stop state reported back
	always @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			enable_o <= 1'h0;
		else if (stop_i)
			enable_o <= 1'h0;  // stop wins over start
		else if (start_i)
			enable_o <= 1'h1;  // only an explicit start restarts
	end
endmodule

//--- verification/drive_stop_fault_sequencer_asserts.sv
// checker for the stop and fault sequencer
`timescale 1ns/1ps
module drive_stop_fault_sequencer_asserts (
	input wire core_clk_i, rst_n_i, enable_i, phase_loss_i, undervoltage_i, hard_fault_i, clear_i,
	input wire enable_loss_response_i, fault_response_select_i, phase_loss_response_i, brake_function_i,
	input wire drive_on_o, current_limit_o, brake_engage_o, ready_to_operate_contact_o, mains_ready_out_o,
	input wire warning_o, error_o,
	input wire [15:0] speed_rpm_i,
	input wire [7:0] status_code_o,
	input wire [1:0] state_o
);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!rst_n_i);
	sequence s_run; state_o == 2'h1 && !hard_fault_i && !undervoltage_i; endsequence
	sequence s_ramp; state_o == 2'h2 && drive_on_o; endsequence
	property p_coast; s_run ##0 ($fell(enable_i) && !enable_loss_response_i && !fault_response_select_i
		&& !brake_function_i) |-> ##[1:4] !drive_on_o; endproperty
	property p_ctrl; s_run ##0 ($fell(enable_i) && enable_loss_response_i && fault_response_select_i)
		|-> ##[1:4] s_ramp; endproperty
	property p_warn; s_run ##0 ($rose(phase_loss_i) && !phase_loss_response_i)
		|-> ##[1:4] (warning_o && mains_ready_out_o && current_limit_o && drive_on_o); endproperty
	property p_perr; $rose(phase_loss_i) && phase_loss_response_i && !hard_fault_i && !undervoltage_i
		|-> ##[1:4] (error_o && !ready_to_operate_contact_o && status_code_o == 8'h19); endproperty
	property p_uv; $rose(undervoltage_i) && !hard_fault_i |-> ##[1:4] (error_o && status_code_o == 8'h05); endproperty
	property p_hard; $rose(hard_fault_i) |-> ##[1:4] (!drive_on_o && error_o && status_code_o == 8'hFF); endproperty
	property p_brake; state_o == 2'h2 && brake_function_i && speed_rpm_i <= 16'h0005
		|-> ##[1:3] brake_engage_o; endproperty
	property p_latch; error_o && !clear_i |=> error_o; endproperty
	a_coast: assert property (p_coast) else $error("coast kept drive on");
	a_ctrl: assert property (p_ctrl) else $error("no controlled ramp");
	a_warn: assert property (p_warn) else $error("phase warning missing");
	a_perr: assert property (p_perr) else $error("phase error missing");
	a_uv: assert property (p_uv) else $error("undervoltage error missing");
	a_hard: assert property (p_hard) else $error("hard fault kept drive on");
	a_brake: assert property (p_brake) else $error("brake not engaged");
	a_latch: assert property (p_latch) else $error("error dropped without clear");
endmodule
bind drive_stop_fault_sequencer drive_stop_fault_sequencer_asserts i_chk (.*);

//--- verification/drive_stop_fault_sequencer_bench.sv
// bench for the stop and fault sequencer
`timescale 1ns/1ps
module drive_stop_fault_sequencer_bench;
	reg core_clk_i = 1'h0, rst_n_i = 1'h0, start = 1'h0, stop = 1'h0, clear_i = 1'h0;
	reg phase_loss_i = 1'h0, undervoltage_i = 1'h0, hard_fault_i = 1'h0, phase_loss_response_i = 1'h0;
	reg enable_loss_response_i = 1'h1, fault_response_select_i = 1'h1, brake_function_i = 1'h0;
	reg [15:0] speed_rpm_i = 16'h0;
	wire ce_i = 1'h1;
	wire [15:0] setpoint_i = 16'h0100;
	wire [15:0] setpoint_o;
	wire enable_i, drive_on_o, current_limit_o, brake_engage_o, ready_to_operate_contact_o, mains_ready_out_o;
	wire warning_o, error_o;
	wire [7:0] status_code_o;
	wire [1:0] state_o;
	integer fail_count = 0, total_checks = 0, k;
	initial forever #50 core_clk_i = ~core_clk_i;
	ctrl_model i_ctrl (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .start_i(start), .stop_i(stop),
		.enable_o(enable_i), .stopped_o());
	drive_stop_fault_sequencer #(.ENABLE_OFF_DELAY_CYC(50), .SETPOINT_RAMP_CYC(10), .BRAKE_TIMEOUT_CYC(200)) i_dut (.*);
	task wrap_up;
		begin
			$display("checks %0d mismatches %0d", total_checks, fail_count);
			if (fail_count == 0 && total_checks > 0)
				$display("[ PASS ]");
			else
				$display("[ FAIL ]");
			$finish;
		end
	endtask
	task cyc(input integer n);
		repeat (n) @(posedge core_clk_i);
	endtask
	task wt(input integer n);
		begin
			cyc(n);
			@(negedge core_clk_i);
		end
	endtask
	task chk(input [15:0] got, input [15:0] exp);
		begin
			total_checks = total_checks + 1;
			if (got !== exp) begin
				fail_count = fail_count + 1;
				$display("mismatch at %0t got %h exp %h", $time, got, exp);
			end
			@(posedge core_clk_i);
		end
	endtask
	task quit;
		begin
			stop <= 1'h1;
			cyc(1);
			stop <= 1'h0;
		end
	endtask
	task go;
		begin
			speed_rpm_i <= 16'h0064;
			start <= 1'h1;
			cyc(1);
			start <= 1'h0;
			for (k = 0; k < 20 && state_o !== 2'h1; k = k + 1)
				cyc(1);
			if (k == 20) begin
				fail_count = fail_count + 1;
				wrap_up;
			end
		end
	endtask
	task ev(input [3:0] v, input [14:0] exp);
		begin
			go;
			{phase_loss_response_i, phase_loss_i, undervoltage_i, hard_fault_i} <= v;
			wt(6);
			chk({state_o == 2'h2, drive_on_o, current_limit_o, error_o, warning_o, mains_ready_out_o,
				ready_to_operate_contact_o, status_code_o}, exp);
			{phase_loss_i, undervoltage_i, hard_fault_i} <= 3'h0;
			wt(6);
			chk({error_o, warning_o, status_code_o}, {exp[11:10], exp[7:0]});
			speed_rpm_i <= 16'h0;
			quit;
			cyc(260);
			clear_i <= 1'h1;
			cyc(2);
			clear_i <= 1'h0;
			wt(4);
			chk({error_o, warning_o, status_code_o}, 10'h0);
			$display("event case done");
		end
	endtask
	task sp(input [2:0] cfg, input [1:0] exp, input [13:0] spx, input slow);
		begin
			{enable_loss_response_i, fault_response_select_i, brake_function_i} <= cfg;
			go;
			quit;
			wt(6);
			chk({state_o == 2'h2, drive_on_o, setpoint_o[13:0]}, {exp, spx});
			if (!slow)
				speed_rpm_i <= 16'h0;
			wt(slow ? 220 : 60);
			chk({brake_engage_o, drive_on_o}, 2'h2);
			$display("stop case done");
		end
	endtask
	initial begin
		cyc(5);
		rst_n_i <= 1'h1;
		wt(3);
		chk({brake_engage_o, drive_on_o, status_code_o}, 10'h200);
		ev(4'h4, 15'h3705);  // phase warning
		ev(4'hC, 15'h6819);  // phase error
		ev(4'h2, 15'h6805);  // undervoltage
		ev(4'h1, 15'h08FF);  // hard fault
		sp(3'h6, 2'h3, 14'h009C, 1'h0);  // controlled stop
		sp(3'h0, 2'h0, 14'h0000, 1'h0);  // coast
		sp(3'h1, 2'h3, 14'h009C, 1'h0);  // brake function
		sp(3'h7, 2'h3, 14'h009C, 1'h1);  // brake timeout
		wrap_up;
	end
endmodule
